/* agkr_defs.svh */
// Offsets, field positions, reset values and timing counts of the gate/reset block
`ifndef AGKR_DEFS_SVH
`define AGKR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define AGKR_OFS_KB_CONTROL 8'h00
`define AGKR_OFS_FAST_CTRL 8'h04
`define AGKR_OFS_KBC_COMMAND 8'h08
`define AGKR_OFS_KBC_DATA 8'h0c
`define AGKR_OFS_SW_CONTROL 8'h10
`define AGKR_OFS_STATUS 8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AGKR_BIT_HW_KBD_RESET_EN 0
`define AGKR_BIT_HW_ADDR_GATE_EN 1
`define AGKR_BIT_FAST_PORT_EN 2
`define AGKR_BIT_FAST_RESET_PULSE 0
`define AGKR_BIT_FAST_GATE_LEVEL 1
`define AGKR_BIT_SW_RESET_LEVEL 0
`define AGKR_BIT_SW_GATE 1
`define AGKR_BIT_DATA_RESET 0
`define AGKR_BIT_DATA_GATE 1

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define AGKR_RST_KB_CONTROL 8'h00
`define AGKR_RST_FAST_CTRL 8'h24
`define AGKR_FAST_RSVD_ONES 8'h24
`define AGKR_RST_SW_CONTROL 8'h01
`define AGKR_KB_CONTROL_MASK 8'hc7

// ----------------------------------------------------------------------------
// Commands
// ----------------------------------------------------------------------------
`define AGKR_CMD_WRITE_OUTPUT 8'hd1
`define AGKR_CMD_PULSE_RESET 8'hfe

// ----------------------------------------------------------------------------
// Timing: least times round up to whole cycles
// ----------------------------------------------------------------------------
`define AGKR_CLK_PERIOD_NS 10
`define AGKR_RESET_DELAY_NS 14000
`define AGKR_RESET_PULSE_NS 6000
`define AGKR_RESET_DELAY_CYCLES \
    ((`AGKR_RESET_DELAY_NS + `AGKR_CLK_PERIOD_NS - 1) / `AGKR_CLK_PERIOD_NS)
`define AGKR_RESET_PULSE_CYCLES \
    ((`AGKR_RESET_PULSE_NS + `AGKR_CLK_PERIOD_NS - 1) / `AGKR_CLK_PERIOD_NS)

`endif

/* agkr_pkg.sv */
// Types shared by the gate/reset block
package agkr_pkg;

    // ------------------------------------------------------------------------
    // Reset pulse sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        AGKR_IDLE,
        AGKR_DELAY,
        AGKR_PULSE
    } agkr_timer_state_t;

endpackage : agkr_pkg

/* agkr_pulse_timer.sv */
// Delayed low-pulse sequencer for the keyboard reset line
`timescale 1ns/1ps
`default_nettype none

module agkr_pulse_timer
    import agkr_pkg::*;
#(
    parameter int DELAY_CYCLES = 1400,
    parameter int PULSE_CYCLES = 600,
    parameter int CNT_W = 16
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    output logic pulse_low,
    output logic busy
);

    agkr_timer_state_t state;
    logic [CNT_W-1:0] count;

    // ------------------------------------------------------------------------
    // Sequencer: wait the delay, then hold low for the pulse width
    // ------------------------------------------------------------------------
    // Starts while busy are dropped so a pulse is never cut short
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= AGKR_IDLE;
            count <= '0;
        end
        else
        begin
            unique case (state)
                AGKR_IDLE:
                begin
                    if (start)
                    begin
                        state <= AGKR_DELAY;
                        count <= CNT_W'(DELAY_CYCLES - 1);
                    end
                end
                AGKR_DELAY:
                begin
                    if (count == '0)
                    begin
                        state <= AGKR_PULSE;
                        count <= CNT_W'(PULSE_CYCLES - 1);
                    end
                    else
                    begin
                        count <= count - 1'b1;
                    end
                end
                AGKR_PULSE:
                begin
                    if (count == '0)
                    begin
                        state <= AGKR_IDLE;
                    end
                    else
                    begin
                        count <= count - 1'b1;
                    end
                end
                default:
                begin
                    state <= AGKR_IDLE;
                end
            endcase
        end
    end

    // Decoded straight from the state register
    assign pulse_low = (state == AGKR_PULSE);
    assign busy = (state != AGKR_IDLE);

endmodule : agkr_pulse_timer

`default_nettype wire

/* agkr_gate_reset.sv */
// Address-line gate and keyboard reset control with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "agkr_defs.svh"

// Operation
// - Hardware reset enable 1 lets hardware logic drive reset; 0 disables it.
// - Data byte after D1 command sets gate from bit 1.
// - Same data byte sets or clears reset output from bit 0.
// - FE command: wait at least 14 us, then reset low at least 6 us.
// - Each output comes from software or hardware control, never both.
// - Fast-port enable merges fast register requests with the other sources.
// - Fast gate level bit 1 drives gate high; 0 leaves gate to the other sources.
// - Writing 1 to fast reset bit while it holds 0: 14 us wait, then low pulse.
// - Fast register resets to 0x24; bits 5,2 read one, 7,6,4,3 zero.
// - Hardware gate enable 1 lets hardware logic drive gate; 0 disables.
// - Fast-port enable 1 lets fast register act; 0 disables it.
module agkr_gate_reset
    import agkr_pkg::*;
#(
    parameter int DELAY_CYCLES = `AGKR_RESET_DELAY_CYCLES,
    parameter int PULSE_CYCLES = `AGKR_RESET_PULSE_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic addr_line_gate,
    output logic kbd_reset_out_n
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [7:0] kb_control;
    logic [1:0] fast_ctrl;
    logic [1:0] sw_control;
    logic hw_gate;
    logic hw_reset_level;
    logic d1_pending;
    logic wr_kb_control;
    logic wr_fast;
    logic wr_sw;
    logic wr_cmd;
    logic wr_data;
    logic [7:0] wdata_byte;
    logic addr_phase;
    logic [31:0] next_rdata;
    logic cmd_pulse_start;
    logic fast_pulse_start;
    logic cmd_pulse_low;
    logic cmd_busy;
    logic fast_pulse_low;
    logic fast_busy;
    logic hw_kbd_reset_en;
    logic hw_addr_gate_en;
    logic fast_port_en;
    logic fast_gate_level;
    logic fast_reset_pulse;
    logic gate_base;
    logic reset_base_n;
    logic next_gate;
    logic next_reset_n;

    // ------------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------------
    function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] ofs);
        is_reg = (addr == ofs);
    endfunction : is_reg

    // Only word transfers are decoded; others complete but are ignored
    assign addr_phase = hsel && hready && htrans[1] && (hsize == 3'b010);
    assign wdata_byte = hwdata[7:0];
    assign wr_kb_control = dp_valid && dp_write && is_reg(dp_addr, `AGKR_OFS_KB_CONTROL);
    assign wr_fast = dp_valid && dp_write && is_reg(dp_addr, `AGKR_OFS_FAST_CTRL);
    assign wr_cmd = dp_valid && dp_write && is_reg(dp_addr, `AGKR_OFS_KBC_COMMAND);
    assign wr_data = dp_valid && dp_write && is_reg(dp_addr, `AGKR_OFS_KBC_DATA);
    assign wr_sw = dp_valid && dp_write && is_reg(dp_addr, `AGKR_OFS_SW_CONTROL);

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------------------
    // Upper address bits are not decoded; the slave window repeats
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end
        else if (hready)
        begin
            dp_valid <= addr_phase;
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------------
    assign hw_kbd_reset_en = kb_control[`AGKR_BIT_HW_KBD_RESET_EN];
    assign hw_addr_gate_en = kb_control[`AGKR_BIT_HW_ADDR_GATE_EN];
    assign fast_port_en = kb_control[`AGKR_BIT_FAST_PORT_EN];
    assign fast_gate_level = fast_ctrl[`AGKR_BIT_FAST_GATE_LEVEL];
    assign fast_reset_pulse = fast_ctrl[`AGKR_BIT_FAST_RESET_PULSE];

    // Keyboard control: enables plus stored clock select bits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            kb_control <= `AGKR_RST_KB_CONTROL;
        end
        else if (wr_kb_control)
        begin
            kb_control <= wdata_byte & `AGKR_KB_CONTROL_MASK;
        end
    end

    // Fast control: only the two low bits are storage
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fast_ctrl <= 2'(`AGKR_RST_FAST_CTRL & 8'h03);
        end
        else if (wr_fast)
        begin
            fast_ctrl <= wdata_byte[1:0];
        end
    end

    // Software levels used when hardware control is off
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sw_control <= 2'(`AGKR_RST_SW_CONTROL & 8'h03);
        end
        else if (wr_sw)
        begin
            sw_control <= wdata_byte[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Command and data reception
    // ------------------------------------------------------------------------
    // Any other command cancels a pending output write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            d1_pending <= 1'b0;
        end
        else if (wr_cmd)
        begin
            d1_pending <= (wdata_byte == `AGKR_CMD_WRITE_OUTPUT);
        end
        else if (wr_data)
        begin
            d1_pending <= 1'b0;
        end
    end

    // Latched hardware levels from the data byte after the output command
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hw_gate <= 1'b0;
            hw_reset_level <= 1'b1;
        end
        else if (wr_data && d1_pending)
        begin
            hw_gate <= wdata_byte[`AGKR_BIT_DATA_GATE];
            hw_reset_level <= wdata_byte[`AGKR_BIT_DATA_RESET];
        end
    end

    // Pulse command only acts while hardware reset control is enabled
    assign cmd_pulse_start = wr_cmd && (wdata_byte == `AGKR_CMD_PULSE_RESET)
        && hw_kbd_reset_en;

    // Fresh zero-to-one write of the pulse bit only; a held 1 never retriggers
    assign fast_pulse_start = wr_fast && wdata_byte[`AGKR_BIT_FAST_RESET_PULSE]
        && !fast_reset_pulse && fast_port_en;

    // ------------------------------------------------------------------------
    // Reset pulse sequencers
    // ------------------------------------------------------------------------
    agkr_pulse_timer #(
        .DELAY_CYCLES(DELAY_CYCLES),
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_cmd_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(cmd_pulse_start),
        .pulse_low(cmd_pulse_low),
        .busy(cmd_busy)
    );

    agkr_pulse_timer #(
        .DELAY_CYCLES(DELAY_CYCLES),
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_fast_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(fast_pulse_start),
        .pulse_low(fast_pulse_low),
        .busy(fast_busy)
    );

    // ------------------------------------------------------------------------
    // Output merge
    // ------------------------------------------------------------------------
    // Hardware and software paths are selected, never combined
    always_comb
    begin
        gate_base = hw_addr_gate_en ? hw_gate : sw_control[`AGKR_BIT_SW_GATE];
        reset_base_n = hw_kbd_reset_en
            ? (hw_reset_level && !cmd_pulse_low)
            : sw_control[`AGKR_BIT_SW_RESET_LEVEL];
        next_gate = gate_base;
        next_reset_n = reset_base_n;
        if (fast_port_en)
        begin
            next_gate = gate_base || fast_gate_level;
            next_reset_n = reset_base_n && !fast_pulse_low;
        end
    end

    // Registered pins so they never glitch on enable changes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_line_gate <= 1'b0;
            kbd_reset_out_n <= 1'b1;
        end
        else
        begin
            addr_line_gate <= next_gate;
            kbd_reset_out_n <= next_reset_n;
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Sampled in the address phase; a write just before is already stored
    // because the master inserts an idle data phase between transfers
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (is_reg(haddr[7:0], `AGKR_OFS_KB_CONTROL))
        begin
            next_rdata[7:0] = kb_control;
        end
        else if (is_reg(haddr[7:0], `AGKR_OFS_FAST_CTRL))
        begin
            next_rdata[7:0] = `AGKR_FAST_RSVD_ONES | {6'h00, fast_ctrl};
        end
        else if (is_reg(haddr[7:0], `AGKR_OFS_SW_CONTROL))
        begin
            next_rdata[7:0] = {6'h00, sw_control};
        end
        else if (is_reg(haddr[7:0], `AGKR_OFS_STATUS))
        begin
            next_rdata[4:0] = {d1_pending, fast_busy, cmd_busy, kbd_reset_out_n,
                addr_line_gate};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (addr_phase && !hwrite)
        begin
            hrdata <= next_rdata;
        end
    end

endmodule : agkr_gate_reset

`default_nettype wire

/* agkr_gate_reset_assertions.sv */
// Port-level checker for the gate/reset block
`timescale 1ns/1ps
`default_nettype none

module agkr_gate_reset_assertions
#(
    parameter int DELAY_CYCLES = 1400,
    parameter int PULSE_CYCLES = 600
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic addr_line_gate,
    input wire logic kbd_reset_out_n
);
    localparam int QUIET = DELAY_CYCLES + PULSE_CYCLES + 4;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic ap, aw, fb, lvl, swl, swg, hg, hl, pend, start;
    logic [7:0] aa;
    logic [2:0] kb;
    logic [15:0] since, lrun;
    wire logic rq_hi = kb[0] ? hl : swl;
    wire logic gq = (kb[1] ? hg : swg) | (kb[2] & lvl);
    wire logic wr = ap & aw;
    wire logic [7:0] wd = hwdata[7:0];

    // ------------------------------------------------------------------
    // Mirror of the register file
    // ------------------------------------------------------------------
    assign start = wr & ((aa == 8'h08 && wd == 8'hfe && kb[0]) ||
                         (aa == 8'h04 && wd[0] && !fb && kb[2]));
    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            {ap, aw, aa} <= '0;
        else
            {ap, aw, aa} <= {hsel & hready & htrans[1] & (hsize == 3'b010), hwrite, haddr[7:0]};
    // Stored at the edge ending the data phase, as the design does
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            {kb, fb, lvl, swl, swg, hg, hl, pend} <= 10'b0000010010;
        else if (wr)
            case (aa)
                8'h00: kb <= wd[2:0];
                8'h04: {lvl, fb} <= wd[1:0];
                8'h08: pend <= (wd == 8'hd1);
                8'h0c: if (pend) {pend, hg, hl} <= {1'b0, wd[1:0]};
                8'h10: {swg, swl} <= wd[1:0];
                default: ;
            endcase
    // Cycles since a timer start, saturating; run length of the low pin
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            {since, lrun} <= {16'hffff, 16'h0};
        else
        begin
            since <= start ? 16'h0 : (since == 16'hffff ? since : since + 16'h1);
            lrun <= kbd_reset_out_n ? 16'h0 : lrun + 16'h1;
        end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_gate_high:
        assert property (gq |=> addr_line_gate) else $error("gate stayed low");
    a_gate_low:
        assert property (!gq |=> !addr_line_gate) else $error("gate stayed high");
    a_reset_low:
        assert property (!rq_hi |=> !kbd_reset_out_n) else $error("reset not low");
    a_reset_idle:
        assert property (rq_hi && since > QUIET |=> kbd_reset_out_n)
        else $error("reset low without cause");
    a_pulse_delay:
        assert property (rq_hi && since < DELAY_CYCLES |=> kbd_reset_out_n)
        else $error("reset pulse too early");
    a_pulse_width:
        assert property ($rose(kbd_reset_out_n) && $past(rq_hi, 2) && since < QUIET
            |-> lrun == PULSE_CYCLES) else $error("reset pulse width wrong");
    a_fast_readback:
        assert property (ap && !aw && aa == 8'h04 |-> hrdata[31:1] == {30'h9, lvl})
        else $error("fast control read wrong");
    a_unmapped_read:
        assert property (ap && !aw && aa > 8'h14 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : agkr_gate_reset_assertions

`default_nettype wire

/* agkr_host_model.sv */
// Host processor model: single-word bus master
`timescale 1ns/1ps
`default_nettype none

module agkr_host_model
(
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Bus idle from time zero
    initial
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;

    // One transfer; call just after a rising edge, returns at the data edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        // Reads get a changing pattern so stale data never looks valid
        hwdata <= w ? d : ~hwdata;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : xfer
endmodule : agkr_host_model

`default_nettype wire

/* agkr_gate_reset_bench.sv */
// Self-checking testbench of the gate/reset block
`timescale 1ns/1ps
`default_nettype none

module agkr_gate_reset_bench;
    import agkr_pkg::*;
    localparam int DLY = 4;
    localparam int PUL = 3;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, gate, rst_n;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int errors = 0;
    int samples_checked = 0;
    int n;

    // ------------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------------
    always #5 hclk = ~hclk;
    agkr_gate_reset #(.DELAY_CYCLES(DLY), .PULSE_CYCLES(PUL)) dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .addr_line_gate(gate), .kbd_reset_out_n(rst_n));
    agkr_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, rd);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd);
        chk(nm, rd, exp);
        chk("okay", {30'h0, hreadyout, hresp}, 32'h2);
    endtask : rdc
    // Pins follow one edge after the storing edge
    task automatic pins(input logic g, input logic r);
        @(posedge hclk);
        #1;
        chk("gate", {31'h0, gate}, {31'h0, g});
        chk("reset_n", {31'h0, rst_n}, {31'h0, r});
        // Back onto a rising edge so the next bus call starts there
        @(posedge hclk);
    endtask : pins
    // Counts the high wait, then the low width, bounded at 40 cycles each
    task automatic pulse(input logic ex);
        n = 0;
        while (rst_n === 1'b1 && n < 40)
        begin
            @(posedge hclk);
            #1;
            n++;
        end
        if (!ex)
            chk("quiet", n, 40);
        else
        begin
            chk("delay", {31'h0, n >= DLY}, 32'h1);
            n = 0;
            while (rst_n === 1'b0 && n < 40)
            begin
                @(posedge hclk);
                #1;
                n++;
            end
            chk("width", n, PUL);
        end
        // Back onto a rising edge so the next bus call starts there
        @(posedge hclk);
    endtask : pulse
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("fast_reset", 8'h04, 32'h24);
        rdc("unmapped", 8'h1c, 32'h0);
        $display("test reset done");
        wr(8'h10, 8'h03);
        pins(1'b1, 1'b1);
        wr(8'h10, 8'h00);
        pins(1'b0, 1'b0);
        wr(8'h10, 8'h01);
        wr(8'h00, 8'h04);
        wr(8'h04, 8'h02);
        pins(1'b1, 1'b1);
        rdc("fast_level", 8'h04, 32'h26);
        wr(8'h00, 8'h00);
        pins(1'b0, 1'b1);
        wr(8'h00, 8'h04);
        wr(8'h04, 8'h00);
        pins(1'b0, 1'b1);
        $display("test fast gate done");
        wr(8'h00, 8'h03);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h08, 8'hd1);
            wr(8'h0c, i[7:0]);
            pins(i[1], i[0]);
        end
        wr(8'h10, 8'h00);
        pins(1'b1, 1'b1);
        wr(8'h10, 8'h01);
        wr(8'h08, 8'hd1);
        wr(8'h0c, 8'h01);
        wr(8'h00, 8'h07);
        wr(8'h04, 8'h02);
        pins(1'b1, 1'b1);
        wr(8'h04, 8'h00);
        pins(1'b0, 1'b1);
        $display("test data byte done");
        wr(8'h00, 8'h01);
        wr(8'h08, 8'hfe);
        pulse(1'b1);
        wr(8'h00, 8'h00);
        wr(8'h08, 8'hfe);
        pulse(1'b0);
        wr(8'h00, 8'h04);
        wr(8'h04, 8'h01);
        pulse(1'b1);
        wr(8'h04, 8'h01);
        pulse(1'b0);
        wr(8'h04, 8'h00);
        wr(8'h04, 8'h01);
        pulse(1'b1);
        $display("test reset pulse done");
        wrap_up();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #100us;
        errors++;
        wrap_up();
    end
endmodule : agkr_gate_reset_bench

bind agkr_gate_reset agkr_gate_reset_assertions #(.DELAY_CYCLES(DELAY_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .addr_line_gate, .kbd_reset_out_n);

`default_nettype wire
